// ### hw/eeprom_target_pkg.sv
// Constants for the two-wire serial EEPROM write-side target.
// Assumes a 10 MHz system clock that samples the serial pins directly.
package eeprom_target_pkg;
   localparam int unsigned CLOCK_HZ                 = 10_000_000;
   localparam int unsigned PROGRAMMING_CYCLE_TIME_US = 5000;
   localparam int unsigned PROGRAM_CYCLES =
      PROGRAMMING_CYCLE_TIME_US * (CLOCK_HZ / 1_000_000);
   localparam logic [3:0] DEVICE_TYPE_CODE = 4'ha;
   localparam int unsigned PAGE_BYTES       = 16;
   localparam int unsigned COLUMN_BITS      = 4;
   localparam logic [2:0] BIT_COUNT_LAST   = 3'h7;
   localparam logic [2:0] BIT_COUNT_FIRST  = 3'h0;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_DEVAD = 3'h1,
      ST_ACK   = 3'h7,
      ST_WORD  = 3'h3,
      ST_DATA  = 3'h2,
      ST_PROG  = 3'h6,
      ST_SKIP  = 3'h5
   } state_t;
endpackage : eeprom_target_pkg

// ### hw/eeprom_write_target.sv
// Write-side logic of a 256 x 8 two-wire EEPROM target.
// Assumes serial clock and data arrive from the bus asynchronously; the
// board resolves the open-drain data wire from sda_out and sda_oe.
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_target #(
   parameter int unsigned PROGRAM_CYCLES = eeprom_target_pkg::PROGRAM_CYCLES,
   parameter bit          IGNORE_SELECT  = 1'b0
) (
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       chip_select_bit2,
   input  wire logic       chip_select_bit1,
   input  wire logic       chip_select_bit0,
   input  wire logic       write_protect,
   output logic            busy,
   output logic            wr_valid,
   input  wire logic       wr_ready,
   output logic [7:0]      wr_addr,
   output logic [7:0]      wr_data,
   output logic            read_selected
);
   if (PROGRAM_CYCLES < 1 || PROGRAM_CYCLES > eeprom_target_pkg::PROGRAM_CYCLES) begin : g_bad
      $error("PROGRAM_CYCLES must be between 1 and the write cycle time");
   end

   localparam int unsigned CW = $clog2(eeprom_target_pkg::PROGRAM_CYCLES + 1);

   // Synchronisers; first stage is read only by the second
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic       scl_prev_reg;
   logic       sda_prev_reg;
   // Strap pins take the same two stages; a change only delays the next decision
   logic [1:0] wp_sync_reg;
   logic [2:0] cs_meta_reg;
   logic [2:0] cs_sync_reg;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
         wp_sync_reg  <= 2'h0;
         cs_meta_reg  <= 3'h0;
         cs_sync_reg  <= 3'h0;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_in};
         sda_sync_reg <= {sda_sync_reg[0], sda_in};
         scl_prev_reg <= scl_sync_reg[1];
         sda_prev_reg <= sda_sync_reg[1];
         wp_sync_reg  <= {wp_sync_reg[0], write_protect};
         cs_meta_reg  <= {chip_select_bit2, chip_select_bit1, chip_select_bit0};
         cs_sync_reg  <= cs_meta_reg;
      end
   end

   wire scl_s    = scl_sync_reg[1];
   wire sda_s    = sda_sync_reg[1];
   wire scl_rise = scl_s & ~scl_prev_reg;
   wire scl_fall = ~scl_s & scl_prev_reg;
   wire start_c  = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
   wire stop_c   = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

   eeprom_target_pkg::state_t state_reg, state_next;
   logic [2:0]    bit_cnt_reg;
   logic [7:0]    shift_reg;
   logic          ack_phase_reg;   // high during the ninth clock
   logic          ack_drive_reg;
   logic [1:0]    next_after_ack_reg;
   logic          is_read_reg;
   logic [7:0]    word_addr_reg;
   logic [7:0]    page_reg [eeprom_target_pkg::PAGE_BYTES];
   logic [eeprom_target_pkg::PAGE_BYTES-1:0] loaded_reg;
   logic [3:0]    drain_idx_reg;
   logic [CW-1:0] prog_cnt_reg;
   logic          prog_pending_reg;

   // Buffer of two entries between page drain and array port
   logic [15:0] buf_reg [2];
   logic        buf_wp_reg;
   logic        buf_rp_reg;
   logic [1:0]  buf_cnt_reg;
   wire buf_full  = (buf_cnt_reg == 2'h2);
   wire buf_empty = (buf_cnt_reg == 2'h0);

   wire [7:0] shifted   = {shift_reg[6:0], sda_s};
   wire [2:0] sel_pins  = cs_sync_reg;
   wire       type_ok   = (shifted[7:4] == eeprom_target_pkg::DEVICE_TYPE_CODE);
   wire       select_ok = IGNORE_SELECT || (shifted[3:1] == sel_pins);
   wire       byte_done = scl_rise && (bit_cnt_reg == eeprom_target_pkg::BIT_COUNT_LAST) && !ack_phase_reg;
   wire [3:0] col       = word_addr_reg[3:0];
   // The word in the output stage must be taken too, or it would stand after busy falls
   wire       prog_done = (state_reg == eeprom_target_pkg::ST_PROG) && !prog_pending_reg
                          && buf_empty && (!wr_valid || wr_ready)
                          && (prog_cnt_reg == CW'(PROGRAM_CYCLES));
   wire       push      = prog_pending_reg && !buf_full && loaded_reg[drain_idx_reg];
   wire       pop       = !buf_empty && (!wr_valid || wr_ready);
   wire       any_loaded = |loaded_reg;

   // Serial state sequencing
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         eeprom_target_pkg::ST_IDLE: if (start_c) state_next = eeprom_target_pkg::ST_DEVAD;
         eeprom_target_pkg::ST_DEVAD: begin
            if (stop_c) state_next = eeprom_target_pkg::ST_IDLE;
            else if (byte_done && !(type_ok && select_ok)) state_next = eeprom_target_pkg::ST_IDLE;
         end
         eeprom_target_pkg::ST_WORD, eeprom_target_pkg::ST_DATA, eeprom_target_pkg::ST_SKIP: begin
            if (start_c) state_next = eeprom_target_pkg::ST_DEVAD;
            // Stop after loaded write bytes begins programming, unless protected
            else if (stop_c && any_loaded && !wp_sync_reg[1]) state_next = eeprom_target_pkg::ST_PROG;
            else if (stop_c) state_next = eeprom_target_pkg::ST_IDLE;
         end
         eeprom_target_pkg::ST_PROG: if (prog_done) state_next = eeprom_target_pkg::ST_IDLE;
         default: state_next = eeprom_target_pkg::ST_IDLE;
      endcase
      if (state_reg != eeprom_target_pkg::ST_PROG && state_reg != eeprom_target_pkg::ST_IDLE
          && byte_done && state_next == state_reg) begin
         if (state_reg == eeprom_target_pkg::ST_DEVAD)
            state_next = shifted[0] ? eeprom_target_pkg::ST_SKIP : eeprom_target_pkg::ST_WORD;
         else if (state_reg == eeprom_target_pkg::ST_WORD)
            state_next = eeprom_target_pkg::ST_DATA;
      end
   end

   // Bit counting and acknowledge timing
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_reg     <= eeprom_target_pkg::ST_IDLE;
         bit_cnt_reg   <= eeprom_target_pkg::BIT_COUNT_FIRST;
         shift_reg     <= 8'h00;
         ack_phase_reg <= 1'b0;
         ack_drive_reg <= 1'b0;
         is_read_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (start_c || state_next != state_reg && state_next != eeprom_target_pkg::ST_WORD
             && state_next != eeprom_target_pkg::ST_SKIP) begin
            bit_cnt_reg   <= eeprom_target_pkg::BIT_COUNT_FIRST;
            ack_phase_reg <= 1'b0;
            ack_drive_reg <= 1'b0;
         end
         if (start_c && state_reg != eeprom_target_pkg::ST_PROG) begin
            bit_cnt_reg   <= eeprom_target_pkg::BIT_COUNT_FIRST;
         end else if (scl_rise && !ack_phase_reg && state_reg != eeprom_target_pkg::ST_PROG) begin
            shift_reg   <= shifted;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (byte_done) begin
               // A refused address leaves for standby without an acknowledge
               ack_phase_reg <= (state_next != eeprom_target_pkg::ST_IDLE);
               if (state_reg == eeprom_target_pkg::ST_DEVAD) is_read_reg <= shifted[0];
            end
         end else if (scl_fall && ack_phase_reg && !ack_drive_reg && bit_cnt_reg == eeprom_target_pkg::BIT_COUNT_FIRST) begin
            // Drive after the fall that ends bit eight, release after the ninth
            ack_drive_reg <= (state_reg != eeprom_target_pkg::ST_SKIP) || is_read_reg;
            ack_phase_reg <= (state_reg != eeprom_target_pkg::ST_SKIP) || is_read_reg;
         end else if (scl_fall && ack_drive_reg) begin
            ack_drive_reg <= 1'b0;
            ack_phase_reg <= 1'b0;
         end
      end
   end

   // Address pointer and page loading
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         word_addr_reg <= 8'h00;
         loaded_reg    <= '0;
      end else if (state_reg == eeprom_target_pkg::ST_PROG) begin
         if (prog_done) loaded_reg <= '0;
      end else if (state_reg == eeprom_target_pkg::ST_DEVAD) begin
         loaded_reg <= '0;
      end else if (byte_done && state_reg == eeprom_target_pkg::ST_WORD) begin
         word_addr_reg <= shifted;
      end else if (byte_done && state_reg == eeprom_target_pkg::ST_DATA) begin
         loaded_reg[col] <= 1'b1;
         word_addr_reg   <= {word_addr_reg[7:4], col + 4'h1};
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < eeprom_target_pkg::PAGE_BYTES; gi++) begin : g_page
         always_ff @(posedge clock or posedge reset) begin
            if (reset) page_reg[gi] <= 8'h00;
            else if (byte_done && state_reg == eeprom_target_pkg::ST_DATA && col == 4'(gi))
               page_reg[gi] <= shifted;
         end
      end
   endgenerate

   // Self-timed programming; bus inputs are ignored meanwhile
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         prog_cnt_reg     <= '0;
         prog_pending_reg <= 1'b0;
         drain_idx_reg    <= 4'h0;
      end else if (state_reg != eeprom_target_pkg::ST_PROG && state_next == eeprom_target_pkg::ST_PROG) begin
         prog_cnt_reg     <= '0;
         prog_pending_reg <= 1'b1;
         drain_idx_reg    <= 4'h0;
      end else if (state_reg == eeprom_target_pkg::ST_PROG) begin
         if (prog_cnt_reg != CW'(PROGRAM_CYCLES)) prog_cnt_reg <= prog_cnt_reg + CW'(1);
         if (prog_pending_reg && (push || !loaded_reg[drain_idx_reg])) begin
            drain_idx_reg <= drain_idx_reg + 4'h1;
            if (drain_idx_reg == 4'hf) prog_pending_reg <= 1'b0;
         end
      end
   end

   // Two-entry buffer toward the array; a stalled array holds programming open
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         buf_reg[0]  <= 16'h0000;
         buf_reg[1]  <= 16'h0000;
         buf_wp_reg  <= 1'b0;
         buf_rp_reg  <= 1'b0;
         buf_cnt_reg <= 2'h0;
         wr_valid    <= 1'b0;
         wr_addr     <= 8'h00;
         wr_data     <= 8'h00;
      end else begin
         if (push) begin
            buf_reg[buf_wp_reg] <= {word_addr_reg[7:4], drain_idx_reg, page_reg[drain_idx_reg]};
            buf_wp_reg          <= ~buf_wp_reg;
         end
         if (pop) begin
            wr_valid   <= 1'b1;
            wr_addr    <= buf_reg[buf_rp_reg][15:8];
            wr_data    <= buf_reg[buf_rp_reg][7:0];
            buf_rp_reg <= ~buf_rp_reg;
         end else if (wr_ready) begin
            wr_valid <= 1'b0;
         end
         buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   // Open drain: output is only ever low, enable pulls the wire
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sda_out       <= 1'b0;
         sda_oe        <= 1'b0;
         busy          <= 1'b0;
         read_selected <= 1'b0;
      end else begin
         sda_out       <= 1'b0;
         sda_oe        <= ack_drive_reg;
         busy          <= (state_next == eeprom_target_pkg::ST_PROG);
         read_selected <= (state_next == eeprom_target_pkg::ST_SKIP) && is_read_reg;
      end
   end
endmodule : eeprom_write_target
`default_nettype wire

// ### test/bus_master_model.sv
// Behavioural two-wire bus master that drives the EEPROM target.
// Assumes an open-drain wire with pull-up resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
   input  wire logic clock,
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_drv
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // Quarter of the 800 ns link period
   task automatic q;
      repeat (2) @(posedge clock);
   endtask : q
   task automatic start_c;
      sda_drv <= 1'b1; q(); scl <= 1'b1; q();
      sda_drv <= 1'b0; q(); scl <= 1'b0; q();
   endtask : start_c
   task automatic stop_c;
      sda_drv <= 1'b0; q(); scl <= 1'b1; q();
      sda_drv <= 1'b1; q(); q();
   endtask : stop_c
   // Eight bits MSB first, data changed only while the clock is low
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_drv <= b[i]; q(); scl <= 1'b1; q(); q(); scl <= 1'b0; q();
      end
      sda_drv <= 1'b1; q(); scl <= 1'b1; q();
      ack = !sda_wire;
      q(); scl <= 1'b0; q();
   endtask : send
endmodule : bus_master_model
`default_nettype wire

// ### test/eeprom_write_target_checker.sv
// Port-level assertions for the EEPROM write target.
// Assumes binding to the target's top-level ports.
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_target_checker #(
   parameter int unsigned PROGRAM_CYCLES = 20
) (
   input wire logic       clock,
   input wire logic       reset,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic       write_protect,
   input wire logic       busy,
   input wire logic       wr_valid,
   input wire logic       wr_ready,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   int unsigned busy_cnt;
   always_ff @(posedge clock or posedge reset)
      if (reset) busy_cnt <= 0;
      else busy_cnt <= busy ? busy_cnt + 1 : 0;
   open_drain_a: assert property (sda_oe |-> !sda_out)
      else $error("data line driven high");
   ack_width_a: assert property ($rose(sda_oe) |-> sda_oe[*6] ##[1:8] !sda_oe)
      else $error("acknowledge width wrong");
   busy_no_ack_a: assert property (busy |-> !sda_oe)
      else $error("acknowledge while programming");
   protect_block_a: assert property ($rose(busy) |-> !write_protect)
      else $error("programming while protected");
   prog_push_a: assert property ($rose(busy) |-> ##[1:20] wr_valid)
      else $error("no array write after stop");
   valid_busy_a: assert property (wr_valid |-> busy)
      else $error("array write outside programming");
   stall_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
      else $error("array write dropped under stall");
   prog_min_a: assert property ($fell(busy) |-> busy_cnt >= PROGRAM_CYCLES - 1)
      else $error("programming too short");
   prog_max_a: assert property (busy |-> busy_cnt < PROGRAM_CYCLES + 100)
      else $error("programming too long");
endmodule : eeprom_write_target_checker
`default_nettype wire

// ### test/test_eeprom_write_target.sv
// Self-checking bench for the EEPROM write target.
// Assumes bus_master_model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_write_target;
   logic       clock, reset, wr_ready, stall, write_protect;
   logic       sda_out, sda_oe, busy, wr_valid, read_selected, scl, sda_drv, a;
   logic [2:0] cs;
   logic [7:0] wr_addr, wr_data, dev;
   logic [7:0] mem [256];
   logic [7:0] exp_mem [256];
   int         errors, tests_run;
   logic       any_oe;
   int         any_acks, acks_before;
   wire        sda_wire = sda_drv & ~(sda_oe & ~sda_out);
   assign dev = {4'ha, cs, 1'b0};
   bus_master_model m (.clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));
   eeprom_write_target #(.PROGRAM_CYCLES(200), .IGNORE_SELECT(1'b0)) uut (
      .clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe(sda_oe), .chip_select_bit2(cs[2]), .chip_select_bit1(cs[1]),
      .chip_select_bit0(cs[0]), .write_protect(write_protect), .busy(busy),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
      .read_selected(read_selected));
   // Five-pin variant listens on the same wire; its acknowledge is counted, not wired in
   eeprom_write_target #(.PROGRAM_CYCLES(200), .IGNORE_SELECT(1'b1)) uut_any (
      .clock(clock), .reset(reset), .scl_in(scl), .sda_in(sda_wire), .sda_out(),
      .sda_oe(any_oe), .chip_select_bit2(cs[2]), .chip_select_bit1(cs[1]),
      .chip_select_bit0(cs[0]), .write_protect(write_protect), .busy(),
      .wr_valid(), .wr_ready(wr_ready), .wr_addr(), .wr_data(),
      .read_selected());
   always @(posedge any_oe) any_acks++;
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // Receiver accepts every other cycle unless stalled
   always @(posedge clock) begin
      if (reset) wr_ready <= 1'b0;
      else wr_ready <= !stall && !wr_ready;
      if (wr_valid && wr_ready) mem[wr_addr] <= wr_data;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      tests_run++;
      if (got !== want) begin
         errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
   endtask : chk
   task automatic xfer(input logic [7:0] d, adr, input int n, input logic [7:0] d0, input logic ea);
      m.start_c();
      m.send(d, a); chk({7'h0, a}, {7'h0, ea});
      if (ea) begin
         m.send(adr, a); chk({7'h0, a}, 8'h01);
         for (int i = 0; i < n; i++) begin
            m.send(d0 + 8'(i), a); chk({7'h0, a}, 8'h01);
         end
      end
      m.stop_c();
   endtask : xfer
   task automatic settle;
      repeat (12) @(posedge clock);
      for (int k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge clock);
      chk({7'h0, busy}, 8'h00);
   endtask : settle
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (40000) @(posedge clock);
      $display("mismatch at %0t: watchdog expired", $time);
      errors++;
      report_and_stop();
   end
   initial begin
      reset = 1'b1; stall = 1'b0; write_protect = 1'b0; cs = 3'h5;
      errors = 0; tests_run = 0;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'h00; exp_mem[i] = 8'h00;
      end
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      repeat (4) @(posedge clock);
      xfer(dev, 8'h35, 1, 8'h5c, 1'b1);
      exp_mem[8'h35] = 8'h5c;
      m.start_c(); m.send(dev, a); m.stop_c();
      chk({7'h0, a}, 8'h00);
      settle();
      xfer(dev, 8'h00, 0, 8'h00, 1'b1);
      $display("byte write and polling done");
      stall <= 1'b1;
      xfer(dev, 8'h4e, 18, 8'h10, 1'b1);
      for (int i = 0; i < 18; i++) exp_mem[{4'h4, 4'(14 + i)}] = 8'h10 + 8'(i);
      repeat (30) @(posedge clock);
      chk({7'h0, wr_valid}, 8'h01);
      stall <= 1'b0;
      settle();
      $display("page wrap done");
      write_protect <= 1'b1;
      xfer(dev, 8'h80, 2, 8'haa, 1'b1);
      settle();
      write_protect <= 1'b0;
      acks_before = any_acks;
      xfer({4'ha, ~cs, 1'b0}, 8'h00, 0, 8'h00, 1'b0);
      chk(8'(any_acks - acks_before), 8'h01);
      acks_before = any_acks;
      xfer({4'hb, cs, 1'b0}, 8'h00, 0, 8'h00, 1'b0);
      chk(8'(any_acks - acks_before), 8'h00);
      m.start_c(); m.send({4'ha, cs, 1'b1}, a);
      chk({6'h0, a, read_selected}, 8'h03);
      m.stop_c();
      settle();
      for (int i = 0; i < 256; i++) chk(mem[i], exp_mem[i]);
      $display("protect, refusal and read done");
      report_and_stop();
   end
endmodule : test_eeprom_write_target
bind eeprom_write_target eeprom_write_target_checker #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) chk_i (
   .clock(clock), .reset(reset), .sda_out(sda_out), .sda_oe(sda_oe),
   .write_protect(write_protect), .busy(busy), .wr_valid(wr_valid), .wr_ready(wr_ready),
   .wr_addr(wr_addr), .wr_data(wr_data));
`default_nettype wire
